/* File: design/smmc_pkg.sv */
package smmc_pkg;

    // config_ctrl_one field positions
    localparam int CFG_IRQ_EN_BIT    = 1;
    localparam int CFG_SPACE_ACC_BIT = 2;
    localparam int CFG_REGION4_BIT   = 7;

    // recognition: asserted samples needed (four clock periods)
    localparam int IRQ_HOLD_CYCLES = 4;

    // header layout, byte offsets below the region top
    localparam logic [7:0] HDR_DR7_OFS   = 8'h04;
    localparam logic [7:0] HDR_FLAGS_OFS = 8'h08;
    localparam logic [7:0] HDR_CR0_OFS   = 8'h0C;
    localparam logic [7:0] HDR_CIP_OFS   = 8'h10;
    localparam logic [7:0] HDR_NIP_OFS   = 8'h14;
    localparam logic [7:0] HDR_CSSEL_OFS = 8'h18;
    localparam logic [7:0] HDR_CSDLO_OFS = 8'h1C;
    localparam logic [7:0] HDR_CSDHI_OFS = 8'h20;
    localparam logic [7:0] HDR_PI_OFS    = 8'h24;
    localparam logic [7:0] HDR_IDX_OFS   = 8'h28;
    localparam int         HDR_WORDS     = 10;

    // reset values loaded on entry
    localparam logic [31:0] DR7_RESET   = 32'h0000_0400;
    localparam logic [31:0] FLAGS_RESET = 32'h0000_0002;
    localparam logic [31:0] CR0_RESET   = 32'h0000_0010;

    // opcodes (escape byte 0F, then the second byte)
    localparam logic [7:0] OP_ESCAPE   = 8'h0F;
    localparam logic [7:0] OP_SV_SEG   = 8'h78;
    localparam logic [7:0] OP_RS_SEG   = 8'h79;
    localparam logic [7:0] OP_SV_TABLE = 8'h7A;
    localparam logic [7:0] OP_RS_TABLE = 8'h7B;
    localparam logic [7:0] OP_SV_TASK  = 8'h7C;
    localparam logic [7:0] OP_RS_TASK  = 8'h7D;
    localparam logic [7:0] OP_RESUME   = 8'hAA;
    localparam int         WIDE_OPERAND_BITS = 80;

    // seg_select_field codes
    localparam logic [2:0] SEG_ES = 3'h0;
    localparam logic [2:0] SEG_CS = 3'h1;
    localparam logic [2:0] SEG_SS = 3'h2;
    localparam logic [2:0] SEG_DS = 3'h3;
    localparam logic [2:0] SEG_FS = 3'h4;
    localparam logic [2:0] SEG_GS = 3'h5;

    typedef enum logic [3:0] {
        OPK_NONE   = 4'h0,
        OPK_SV_SEG = 4'h1,
        OPK_RS_SEG = 4'h2,
        OPK_SV_TBL = 4'h3,
        OPK_RS_TBL = 4'h4,
        OPK_SV_TSK = 4'h5,
        OPK_RS_TSK = 4'h6,
        OPK_RESUME = 4'h7
    } smmc_opk_t;

    typedef struct packed {
        logic [31:0] dr7;
        logic [31:0] flags;
        logic [31:0] cr0;
        logic [31:0] curIp;
        logic [31:0] nextIp;
        logic [15:0] csSel;
        logic [63:0] csDesc;
        logic        repPrefix;
        logic        ioWrite;
        logic [31:0] restIdx;
    } smmc_hdr_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  op0;
        logic [7:0]  op1;
        logic [7:0]  modrm;
        logic [1:0]  privLevel;
    } smmc_instr_t;

    typedef struct packed {
        logic        valid;
        logic        legal;
        logic        invalidOp;
        smmc_opk_t   kind;
        logic [2:0]  seg;
        logic [6:0]  memBits;
    } smmc_dec_t;

endpackage

/* File: design/smmc_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module smmc_decode
    import smmc_pkg::*;
(
    // clock and reset
    input  wire logic  ref_clk,
    input  wire logic  srst,
    // instruction in
    input  var  smmc_instr_t instr,
    input  wire logic  spaceAccess,
    input  wire logic  inRoutineIrq,
    // result
    output var  smmc_dec_t   dec
);

    typedef struct packed {
        smmc_dec_t decR;
    } smmc_dstate_t;

    smmc_dstate_t st_r;
    smmc_dstate_t st_nxt;

    function automatic smmc_opk_t classify(input logic [7:0] o1);
        unique case (o1)
            OP_SV_SEG:   classify = OPK_SV_SEG;
            OP_SV_TABLE: classify = OPK_SV_TBL;
            OP_SV_TASK:  classify = OPK_SV_TSK;
            OP_RS_SEG:   classify = OPK_RS_SEG;
            OP_RS_TABLE: classify = OPK_RS_TBL;
            OP_RS_TASK:  classify = OPK_RS_TSK;
            OP_RESUME:   classify = OPK_RESUME;
            default:     classify = OPK_NONE;
        endcase
    endfunction

    always_comb begin
        smmc_opk_t k;
        logic      fmtOk;
        logic      allowed;
        k      = OPK_NONE;
        fmtOk  = 1'b0;
        allowed = 1'b0;
        st_nxt = '0;
        if (instr.valid && instr.op0 == OP_ESCAPE) begin
            k = classify(instr.op1);
        end
        unique case (k)
            OPK_SV_SEG, OPK_RS_SEG: begin
                // only DS/ES/FS/GS/SS; CS comes back through resume
                fmtOk = instr.modrm[5:3] inside {SEG_DS, SEG_ES, SEG_FS, SEG_GS, SEG_SS};
            end
            OPK_SV_TBL, OPK_RS_TBL, OPK_SV_TSK, OPK_RS_TSK: begin
                fmtOk = (instr.modrm[5:3] == 3'h0);
            end
            OPK_RESUME: fmtOk = 1'b1;
            OPK_NONE:   fmtOk = 1'b0;
        endcase
        // no region check on the fetch address
        allowed = (instr.privLevel == 2'h0) && (spaceAccess || inRoutineIrq);
        st_nxt.decR.valid     = (k != OPK_NONE);
        st_nxt.decR.kind      = k;
        st_nxt.decR.seg       = instr.modrm[5:3];
        st_nxt.decR.legal     = (k != OPK_NONE) && fmtOk && allowed;
        st_nxt.decR.invalidOp = (k != OPK_NONE) && !(fmtOk && allowed);
        st_nxt.decR.memBits   = (k == OPK_NONE || k == OPK_RESUME) ? 7'h00
                                : 7'(WIDE_OPERAND_BITS);
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dec = st_r.decR;

endmodule
`default_nettype wire

/* File: design/smmc_core.sv */
// How it works
// - management interrupt outranks every other request
// - recognize only with enable, region, size set
// - write state header before changing state
// - then real mode, fetch at region base
// - header holds control, flags, pointers, code segment
// - current and next pointers saved correctly
// - string I/O trap: equal pointers, valid flags
// - prefix flag set when repeat prefix
// - direction flag set for I/O write
// - header holds restored index value
// - save/restore need level 0 and access condition
// - instructions allowed outside management region
// - non-resume instructions move 80-bit operand
// - save opcodes 0F 78, 7A, 7C
// - restore opcodes 0F 79, 7B, 7D
// - segment ops select DS ES FS GS SS
// - table and task ops need reg 000
// - resume leaves mode, reloads header, continues
// - all state held while clock stopped
// - region accesses use management strobe in mode
// - after save reset control, flags, debug; load code
// - region accesses noncacheable, pipelining allowed
`timescale 1ns/1ps
`default_nettype none
module smmc_core
    import smmc_pkg::*;
#(
    parameter int HOLD_CYCLES = IRQ_HOLD_CYCLES
)(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        srst,
    // interrupt pin and configuration
    input  wire logic        mgmt_irq_n,
    input  wire logic [7:0]  config_ctrl_one,
    input  wire logic [31:0] region4Base,
    input  wire logic [3:0]  region4Size,
    // other interrupt requests
    input  wire logic        nmiReq,
    input  wire logic        intrReq,
    // processor state to save
    input  var  smmc_hdr_t   cpuState,
    input  wire logic        ioTrapStr,
    // instruction stream
    input  var  smmc_instr_t instr,
    // memory access from the core
    input  wire logic        memReq,
    input  wire logic [31:0] memAddr,
    // header write port
    output logic             hdrWrEn,
    output logic [31:0]      hdrWrAddr,
    output logic [31:0]      hdrWrData,
    input  wire logic        hdrWrAck,
    // entry, exit and mode status
    output logic             system_mgmt_state,
    output logic             realModeLoad,
    output logic [31:0]      fetchAddr,
    output logic             fetchLoad,
    output logic [31:0]      control_reg_zero,
    output logic [31:0]      extended_flags,
    output logic [31:0]      debug_ctrl_word,
    output logic [31:0]      csBase,
    output logic [31:0]      csLimit,
    output logic             resumeLoad,
    output smmc_hdr_t        restoredState,
    // interrupt selection
    output logic [1:0]       serviceSel,
    // instruction results
    output logic             invalidOpcode,
    output logic             mgmtInstrGo,
    output logic [6:0]       operandBits,
    // bus strobes
    output logic             mgmt_region_strobe_n,
    output logic             normal_addr_strobe_n,
    output logic             nonCacheable
);

    // ********************************
    // state
    // ********************************
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_SAVE  = 4'b0010,
        ST_ENTER = 4'b0100,
        ST_RUN   = 4'b1000
    } smmc_st_t;

    typedef struct packed {
        logic              pinS1;
        logic              pinS2;
        logic [3:0]        cnt;
        logic              pend;
        smmc_st_t          fsm;
        logic [3:0]        wIdx;
        smmc_hdr_t         hdr;
        logic [31:0]       top;
        logic              inMode;
        logic              wrEn;
        logic [31:0]       wrAddr;
        logic [31:0]       wrData;
        logic              rmLoad;
        logic [31:0]       fAddr;
        logic              fLoad;
        logic [31:0]       cr0;
        logic [31:0]       flg;
        logic [31:0]       dr7;
        logic [31:0]       csB;
        logic [31:0]       csL;
        logic              resLoad;
        smmc_hdr_t         resState;
        logic [1:0]        sel;
        logic              inv;
        logic              go;
        logic [6:0]        opBits;
        logic              smStrobeN;
        logic              nStrobeN;
        logic              nc;
    } smmc_state_t;

    smmc_state_t st_r;
    smmc_state_t st_nxt;
    smmc_dec_t   dec;

    function automatic logic [31:0] regionBytes(input logic [3:0] sz);
        regionBytes = (sz == 4'h0) ? 32'h0000_0000 : (32'h0000_0800 << sz);
    endfunction

    function automatic logic inRegion(input logic [31:0] a, input logic [31:0] b, input logic [3:0] sz);
        inRegion = (sz != 4'h0) && (a >= b) && (a < b + regionBytes(sz));
    endfunction

    wire logic recogOk = config_ctrl_one[CFG_IRQ_EN_BIT] && !config_ctrl_one[CFG_SPACE_ACC_BIT]
                         && config_ctrl_one[CFG_REGION4_BIT] && (region4Size != 4'h0);

    // ********************************
    // instruction decode
    // ********************************
    smmc_decode u_dec (
        .ref_clk      (ref_clk),
        .srst         (srst),
        .instr        (instr),
        .spaceAccess  (config_ctrl_one[CFG_SPACE_ACC_BIT]),
        .inRoutineIrq (st_r.inMode && !st_r.pinS2),
        .dec          (dec)
    );

    // ********************************
    // next state
    // ********************************
    always_comb begin
        logic [31:0] word;
        logic        inReg;
        word   = 32'h0000_0000;
        inReg  = 1'b0;
        st_nxt = st_r;
        st_nxt.pinS1   = mgmt_irq_n;
        st_nxt.pinS2   = st_r.pinS1;
        st_nxt.rmLoad  = 1'b0;
        st_nxt.fLoad   = 1'b0;
        st_nxt.resLoad = 1'b0;
        st_nxt.inv     = 1'b0;
        st_nxt.go      = 1'b0;

        // pin sampled every clock, consecutive lows counted
        if (st_r.pinS2) begin
            st_nxt.cnt = 4'h0;
        end else if (st_r.cnt < 4'(HOLD_CYCLES)) begin
            st_nxt.cnt = st_r.cnt + 4'h1;
        end
        if (!st_r.pinS2 && st_r.cnt == 4'(HOLD_CYCLES - 1) && recogOk && !st_r.inMode) begin
            st_nxt.pend = 1'b1;
        end

        // management first, then nmi, then intr
        if (st_r.pend || st_nxt.pend) begin
            st_nxt.sel = 2'h3;
        end else if (nmiReq) begin
            st_nxt.sel = 2'h2;
        end else if (intrReq) begin
            st_nxt.sel = 2'h1;
        end else begin
            st_nxt.sel = 2'h0;
        end

        unique case (st_r.fsm)
            ST_IDLE: begin
                if (st_r.pend) begin
                    st_nxt.pend = 1'b0;
                    st_nxt.hdr  = cpuState;
                    st_nxt.hdr.nextIp = ioTrapStr ? cpuState.curIp : cpuState.nextIp;
                    st_nxt.hdr.repPrefix = ioTrapStr && cpuState.repPrefix;
                    st_nxt.hdr.ioWrite   = ioTrapStr && cpuState.ioWrite;
                    st_nxt.hdr.restIdx   = cpuState.restIdx;
                    st_nxt.top  = region4Base + regionBytes(region4Size);
                    st_nxt.wIdx = 4'h0;
                    st_nxt.wrEn = 1'b0;
                    st_nxt.fsm  = ST_SAVE;
                end
            end
            ST_SAVE: begin
                if (!st_r.wrEn || hdrWrAck) begin
                    if (st_r.wrEn) begin
                        st_nxt.wIdx = st_r.wIdx + 4'h1;
                    end
                    if (st_r.wrEn && st_r.wIdx == 4'(HDR_WORDS - 1)) begin
                        st_nxt.wrEn = 1'b0;
                        st_nxt.fsm  = ST_ENTER;
                    end else begin
                        unique case (st_nxt.wIdx)
                            4'h0:    word = st_r.hdr.dr7;
                            4'h1:    word = st_r.hdr.flags;
                            4'h2:    word = st_r.hdr.cr0;
                            4'h3:    word = st_r.hdr.curIp;
                            4'h4:    word = st_r.hdr.nextIp;
                            4'h5:    word = {16'h0000, st_r.hdr.csSel};
                            4'h6:    word = st_r.hdr.csDesc[31:0];
                            4'h7:    word = st_r.hdr.csDesc[63:32];
                            4'h8:    word = {30'h0000_0000, st_r.hdr.ioWrite, st_r.hdr.repPrefix};
                            default: word = st_r.hdr.restIdx;
                        endcase
                        st_nxt.wrEn   = 1'b1;
                        st_nxt.wrData = word;
                        st_nxt.wrAddr = st_r.top - 32'(HDR_DR7_OFS) - {26'h0, st_nxt.wIdx, 2'b00};
                    end
                end
            end
            ST_ENTER: begin
                // state altered only after header written
                st_nxt.cr0    = CR0_RESET;
                st_nxt.flg    = FLAGS_RESET;
                st_nxt.dr7    = DR7_RESET;
                st_nxt.csB    = region4Base;
                st_nxt.csL    = regionBytes(region4Size) - 32'h0000_0001;
                st_nxt.rmLoad = 1'b1;
                st_nxt.fAddr  = region4Base;
                st_nxt.fLoad  = 1'b1;
                st_nxt.inMode = 1'b1;
                st_nxt.fsm    = ST_RUN;
            end
            ST_RUN: begin
                if (dec.valid && dec.legal && dec.kind == OPK_RESUME) begin
                    st_nxt.resState = st_r.hdr;
                    st_nxt.resLoad  = 1'b1;
                    st_nxt.fAddr    = st_r.hdr.nextIp;
                    st_nxt.fLoad    = 1'b1;
                    st_nxt.cr0      = st_r.hdr.cr0;
                    st_nxt.flg      = st_r.hdr.flags;
                    st_nxt.dr7      = st_r.hdr.dr7;
                    st_nxt.inMode   = 1'b0;
                    st_nxt.fsm      = ST_IDLE;
                end
            end
            default: st_nxt.fsm = ST_IDLE;
        endcase

        // save/restore instruction outcome
        if (dec.valid) begin
            st_nxt.inv    = dec.invalidOp;
            st_nxt.go     = dec.legal && dec.kind != OPK_RESUME;
            st_nxt.opBits = dec.memBits;
        end

        // strobe steering and cacheability
        inReg = inRegion(memAddr, region4Base, region4Size) && config_ctrl_one[CFG_REGION4_BIT];
        st_nxt.smStrobeN = !(memReq && inReg && st_r.inMode);
        st_nxt.nStrobeN  = !(memReq && !(inReg && st_r.inMode));
        st_nxt.nc        = memReq && inReg;
    end

    // ********************************
    // registers, static: nothing decays
    // ********************************
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_r           <= '0;
            st_r.pinS1     <= 1'b1;
            st_r.pinS2     <= 1'b1;
            st_r.fsm       <= ST_IDLE;
            st_r.cr0       <= CR0_RESET;
            st_r.flg       <= FLAGS_RESET;
            st_r.dr7       <= DR7_RESET;
            st_r.smStrobeN <= 1'b1;
            st_r.nStrobeN  <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign hdrWrEn              = st_r.wrEn;
    assign hdrWrAddr            = st_r.wrAddr;
    assign hdrWrData            = st_r.wrData;
    assign system_mgmt_state    = st_r.inMode;
    assign realModeLoad         = st_r.rmLoad;
    assign fetchAddr            = st_r.fAddr;
    assign fetchLoad            = st_r.fLoad;
    assign control_reg_zero     = st_r.cr0;
    assign extended_flags       = st_r.flg;
    assign debug_ctrl_word      = st_r.dr7;
    assign csBase               = st_r.csB;
    assign csLimit              = st_r.csL;
    assign resumeLoad           = st_r.resLoad;
    assign restoredState        = st_r.resState;
    assign serviceSel           = st_r.sel;
    assign invalidOpcode        = st_r.inv;
    assign mgmtInstrGo          = st_r.go;
    assign operandBits          = st_r.opBits;
    assign mgmt_region_strobe_n = st_r.smStrobeN;
    assign normal_addr_strobe_n = st_r.nStrobeN;
    assign nonCacheable         = st_r.nc;

endmodule
`default_nettype wire

/* File: dv/smmc_core_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module smmc_core_asserts
    import smmc_pkg::*;
(
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        srst,
    // configuration and requests
    input wire logic [7:0]  config_ctrl_one,
    input wire logic [31:0] region4Base,
    input wire logic [3:0]  region4Size,
    input var  smmc_instr_t instr,
    input wire logic        memReq,
    input wire logic [31:0] memAddr,
    // header port
    input wire logic        hdrWrEn,
    input wire logic [31:0] hdrWrAddr,
    input wire logic [31:0] hdrWrData,
    input wire logic        hdrWrAck,
    // mode and results
    input wire logic        system_mgmt_state,
    input wire logic        realModeLoad,
    input wire logic [31:0] fetchAddr,
    input wire logic        fetchLoad,
    input wire logic [31:0] control_reg_zero,
    input wire logic [31:0] extended_flags,
    input wire logic [31:0] debug_ctrl_word,
    input wire logic        resumeLoad,
    input var  smmc_hdr_t   restoredState,
    input wire logic        invalidOpcode,
    input wire logic        mgmtInstrGo,
    input wire logic [6:0]  operandBits,
    input wire logic        mgmt_region_strobe_n,
    input wire logic        normal_addr_strobe_n,
    input wire logic        nonCacheable
);
    // ****************************************
    // properties
    // ****************************************
    wire logic [31:0] top    = region4Base + (32'h0000_0800 << region4Size);
    wire logic        inRgn  = (region4Size != 4'h0) && memAddr >= region4Base && memAddr < top;
    wire logic        mgmtOp = instr.valid && instr.op0 == OP_ESCAPE && instr.op1 inside {[8'h78:8'h7D]};
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    a_cfg_gate: assert property ($rose(hdrWrEn) && !system_mgmt_state |-> config_ctrl_one[1]
        && !config_ctrl_one[2] && config_ctrl_one[7] && region4Size != 4'h0) else $error("entry with bad config");
    a_no_reentry: assert property ($rose(hdrWrEn) |-> !system_mgmt_state) else $error("entry while in mode");
    a_hdr_hold: assert property (hdrWrEn && !hdrWrAck |=> hdrWrEn && $stable(hdrWrAddr)
        && $stable(hdrWrData)) else $error("header word dropped");
    a_hdr_addr: assert property (hdrWrEn |-> hdrWrAddr < top && hdrWrAddr >= top - 32'd40)
        else $error("header word outside top");
    a_entry_fetch: assert property ($rose(system_mgmt_state) |-> realModeLoad && fetchLoad
        && fetchAddr == region4Base) else $error("entry fetch wrong");
    a_entry_regs: assert property ($rose(system_mgmt_state) |-> control_reg_zero == CR0_RESET
        && extended_flags == FLAGS_RESET && debug_ctrl_word == DR7_RESET) else $error("entry regs wrong");
    a_strobe_mode: assert property (memReq && system_mgmt_state && inRgn |=> !mgmt_region_strobe_n
        && normal_addr_strobe_n && nonCacheable) else $error("region strobe wrong");
    a_strobe_normal: assert property (memReq && !inRgn |=> !normal_addr_strobe_n
        && mgmt_region_strobe_n) else $error("normal strobe wrong");
    a_priv_invalid: assert property (mgmtOp && instr.privLevel != 2'h0 |-> ##2 invalidOpcode
        && !mgmtInstrGo) else $error("privilege not enforced");
    a_operand_width: assert property (mgmtOp |-> ##2 (!mgmtInstrGo || operandBits == 7'd80))
        else $error("operand width wrong");
    a_resume_exit: assert property (resumeLoad |-> fetchLoad && fetchAddr == restoredState.nextIp)
        else $error("resume target wrong");
    c_entry: cover property ($rose(system_mgmt_state));
    c_resume: cover property (resumeLoad);
    c_invalid: cover property (invalidOpcode);
    c_region: cover property (memReq && system_mgmt_state && inRgn);
endmodule
bind smmc_core smmc_core_asserts u_chk (.*);
`default_nettype wire

/* File: dv/smmc_pm_model.sv */
`timescale 1ns/1ps
`default_nettype none
module smmc_pm_model (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        srst,
    // bench control
    input  wire logic        pullLow,
    input  wire logic        slowAck,
    // header memory side
    input  wire logic        hdrWrEn,
    input  wire logic [31:0] hdrWrAddr,
    input  wire logic [31:0] hdrWrData,
    output logic             hdrWrAck,
    // pin
    output logic             mgmt_irq_n
);
    // ****************************************
    // pin driver and header store
    // ****************************************
    logic [31:0] words [16];
    logic [31:0] addrs [16];
    logic [3:0]  cnt;
    logic [1:0]  gap;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mgmt_irq_n <= 1'b1;
            hdrWrAck   <= 1'b0;
            cnt        <= 4'h0;
            gap        <= 2'h0;
        end else begin
            mgmt_irq_n <= !pullLow;
            hdrWrAck   <= 1'b0;
            if (hdrWrEn && !hdrWrAck) begin
                gap <= gap + 2'h1;
                if (!slowAck || gap == 2'h3) hdrWrAck <= 1'b1;
            end
            if (hdrWrEn && hdrWrAck) begin
                words[cnt] <= hdrWrData;
                addrs[cnt] <= hdrWrAddr;
                cnt        <= cnt + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: dv/test_system_mgmt_mode_control.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("FAIL %s exp %0h got %0h", n, e, g); end end
`define WAITF(c) begin for (int k = 0; k < 300 && !(c); k++) @(negedge ref_clk); \
    if (!(c)) begin miscompares++; end_of_test(); end end
module test_system_mgmt_mode_control;
    import smmc_pkg::*;
    // ****************************************
    // stimulus and checks
    // ****************************************
    localparam logic [31:0] BASE = 32'h0003_0000;
    localparam logic [31:0] TOP  = 32'h0003_8000;
    logic ref_clk = 0, srst = 1, pullLow = 0, slowAck = 0, mgmt_irq_n, nmiReq = 0, intrReq = 0;
    logic [7:0] config_ctrl_one = 8'h82;
    logic [31:0] region4Base = BASE;
    logic [3:0] region4Size = 4'h4;
    smmc_hdr_t cpuState = '{32'h0000_0455, 32'h0000_0246, 32'h0000_0011, 32'h0000_1230,
        32'h0000_1234, 16'h00F0, 64'h1122_3344_5566_7788, 1'b1, 1'b0, 32'h0000_0ABC};
    logic ioTrapStr = 1;
    smmc_instr_t instr = '0;
    logic memReq = 0;
    logic [31:0] memAddr = '0;
    logic hdrWrEn, hdrWrAck, system_mgmt_state, realModeLoad, fetchLoad, resumeLoad;
    logic [31:0] hdrWrAddr, hdrWrData, fetchAddr, control_reg_zero, extended_flags;
    logic [31:0] debug_ctrl_word, csBase, csLimit;
    smmc_hdr_t restoredState;
    logic [1:0] serviceSel;
    logic invalidOpcode, mgmtInstrGo, mgmt_region_strobe_n, normal_addr_strobe_n, nonCacheable;
    logic [6:0] operandBits;
    logic [31:0] expW [10];
    logic [7:0] badCfg [4] = '{8'h80, 8'h86, 8'h02, 8'h82};
    logic [7:0] tOp [9] = '{OP_SV_SEG, OP_RS_SEG, OP_SV_SEG, OP_RS_SEG, OP_SV_TABLE, OP_RS_TABLE,
        OP_SV_TASK, OP_RS_TASK, OP_RS_TABLE};
    logic [7:0] tMr [9] = '{8'h18, 8'h20, 8'h08, 8'h28, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08};
    logic [8:0] tGo = 9'h0FB;
    int miscompares = 0, num_checks = 0;
    always #5 ref_clk = ~ref_clk;
    smmc_pm_model i_pm (.*);
    smmc_core #(.HOLD_CYCLES(IRQ_HOLD_CYCLES)) i_dut (.*);
    task end_of_test;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task do_instr(input logic [7:0] op, mr, input logic [1:0] pl, input logic go);
        instr = '{1'b1, OP_ESCAPE, op, mr, pl};
        @(negedge ref_clk);
        instr.valid = 1'b0;
        @(negedge ref_clk);
        `CHK("go", go, mgmtInstrGo)
        `CHK("invalid", !go, invalidOpcode)
        if (go) `CHK("bits", 7'd80, operandBits)
    endtask
    task mem_acc(input logic [31:0] a, input logic m);
        memReq = 1'b1;
        memAddr = a;
        @(negedge ref_clk);
        memReq = 1'b0;
        `CHK("region strobe", !m, mgmt_region_strobe_n)
        `CHK("normal strobe", m, normal_addr_strobe_n)
        if (m) `CHK("noncacheable", 1'b1, nonCacheable)
    endtask
    task no_entry(input int n);
        logic saw;
        saw = 1'b0;
        repeat (n) begin
            @(negedge ref_clk);
            saw |= hdrWrEn;
        end
        `CHK("entry", 1'b0, saw)
    endtask
    initial begin
        repeat (4) @(negedge ref_clk);
        srst = 1'b0;
        `CHK("idle strobe", 1'b1, normal_addr_strobe_n)
        `CHK("mode", 1'b0, system_mgmt_state)
        nmiReq = 1'b1;
        intrReq = 1'b1;
        `WAITF(serviceSel == 2'h2)
        `CHK("nmi first", 2'h2, serviceSel)
        $display("test priority done");
        for (int i = 0; i < 4; i++) begin
            config_ctrl_one = badCfg[i];
            region4Size = (i == 3) ? 4'h0 : 4'h4;
            pullLow = 1'b1;
            no_entry(12);
            pullLow = 1'b0;
            repeat (6) @(negedge ref_clk);
        end
        config_ctrl_one = 8'h82;
        region4Size = 4'h4;
        pullLow = 1'b1;
        repeat (3) @(negedge ref_clk);
        pullLow = 1'b0;
        no_entry(12);
        $display("test refusal done");
        config_ctrl_one = 8'h86;
        do_instr(OP_SV_SEG, 8'h18, 2'h0, 1'b1);
        do_instr(OP_SV_SEG, 8'h18, 2'h1, 1'b0);
        config_ctrl_one = 8'h82;
        do_instr(OP_SV_TABLE, 8'h00, 2'h0, 1'b0);
        $display("test outside done");
        slowAck = 1'b1;
        pullLow = 1'b1;
        `WAITF(serviceSel == 2'h3)
        `CHK("mgmt first", 2'h3, serviceSel)
        `WAITF(system_mgmt_state)
        nmiReq = 1'b0;
        intrReq = 1'b0;
        `CHK("fetch", BASE, fetchAddr)
        `CHK("cr0", CR0_RESET, control_reg_zero)
        `CHK("flags", FLAGS_RESET, extended_flags)
        `CHK("dr7", DR7_RESET, debug_ctrl_word)
        `CHK("cs base", BASE, csBase)
        `CHK("cs limit", TOP - BASE - 32'h0000_0001, csLimit)
        expW = '{cpuState.dr7, cpuState.flags, cpuState.cr0, cpuState.curIp, cpuState.curIp,
            {16'h0000, cpuState.csSel}, cpuState.csDesc[31:0], cpuState.csDesc[63:32],
            32'h0000_0001, cpuState.restIdx};
        `CHK("words", 4'hA, i_pm.cnt)
        for (int i = 0; i < 10; i++) begin
            `CHK("hdr addr", TOP - 32'(4 * (i + 1)), i_pm.addrs[i])
            `CHK("hdr data", expW[i], i_pm.words[i])
        end
        do_instr(OP_RS_SEG, 8'h10, 2'h0, 1'b1);
        config_ctrl_one = 8'h86;
        pullLow = 1'b0;
        for (int i = 0; i < 9; i++) do_instr(tOp[i], tMr[i], 2'h0, tGo[i]);
        mem_acc(BASE + 32'h0000_0100, 1'b1);
        mem_acc(TOP, 1'b0);
        $display("test entry done");
        instr = '{1'b1, OP_ESCAPE, OP_RESUME, 8'h00, 2'h0};
        @(negedge ref_clk);
        instr.valid = 1'b0;
        `WAITF(resumeLoad)
        `CHK("resume fetch", cpuState.curIp, fetchAddr)
        `CHK("restored dr7", cpuState.dr7, restoredState.dr7)
        repeat (2) @(negedge ref_clk);
        `CHK("mode exit", 1'b0, system_mgmt_state)
        mem_acc(BASE + 32'h0000_0100, 1'b0);
        $display("test resume done");
        end_of_test();
    end
endmodule
`default_nettype wire
